// >>> common/hwmon_pkg.sv
package hwmon_pkg;
// Contract
// - flag high when value > high limit, low when value <= low limit
// - bit 0 of config 0x40 starts and stops round-robin monitoring
// - store each result in its value register, then compare it
// - slots: 11.38 ms per supply, 12 ms local, 25.5 ms per remote
// - wait 35 ms after the last channel before restarting
// - fan checks run independently of the analog sequence
// - fan period above its 16-bit two-byte limit flags a slow fan
// - an out-of-limit comparison sets that channel's status bit
// - status is sticky; a read clears only once the cause has gone
// - primary bit 7 reads 1 whenever any secondary bit is set
// - primary bits: 6 remote b, 5 local, 4 remote a, 2 and 0 supply
// - secondary: 7,6 diodes, 4..2 fans, 1 overtemp, 0 unused
// - secondary bit 5: fan d, or pin time limit in pin mode
// - masks at 0x74/0x75 gate only the alert, never status
// - alert low while out of limit and until status is read
// - alert can be routed to either of two pins by config
// - alert disabled after reset until its enable bit is set
// - clearing a mask lets current status drive the alert again

localparam logic [7:0] ADDR_CONFIG_1            = 8'h40;
localparam logic [7:0] ADDR_STATUS_PRIMARY      = 8'h41;
localparam logic [7:0] ADDR_STATUS_SECONDARY    = 8'h42;
localparam logic [7:0] ADDR_MASK_1              = 8'h74;
localparam logic [7:0] ADDR_MASK_2              = 8'h75;
localparam logic [7:0] ADDR_CONFIG_3            = 8'h78;
localparam logic [7:0] ADDR_CONFIG_4            = 8'h7d;
localparam logic [7:0] ADDR_SUPPLY_A_VALUE      = 8'h20;
localparam logic [7:0] ADDR_SUPPLY_B_VALUE      = 8'h21;
localparam logic [7:0] ADDR_REMOTE_A_VALUE      = 8'h25;
localparam logic [7:0] ADDR_LOCAL_VALUE         = 8'h26;
localparam logic [7:0] ADDR_REMOTE_B_VALUE      = 8'h27;
localparam logic [7:0] ADDR_SUPPLY_A_LOW_LIMIT  = 8'h44;
localparam logic [7:0] ADDR_SUPPLY_A_HIGH_LIMIT = 8'h45;
localparam logic [7:0] ADDR_SUPPLY_B_LOW_LIMIT  = 8'h48;
localparam logic [7:0] ADDR_SUPPLY_B_HIGH_LIMIT = 8'h49;
localparam logic [7:0] ADDR_REMOTE_A_TEMP_LOW_LIMIT  = 8'h4e;
localparam logic [7:0] ADDR_REMOTE_A_TEMP_HIGH_LIMIT = 8'h4f;
localparam logic [7:0] ADDR_LOCAL_TEMP_LOW_LIMIT     = 8'h50;
localparam logic [7:0] ADDR_LOCAL_TEMP_HIGH_LIMIT    = 8'h51;
localparam logic [7:0] ADDR_REMOTE_B_TEMP_LOW_LIMIT  = 8'h52;
localparam logic [7:0] ADDR_REMOTE_B_TEMP_HIGH_LIMIT = 8'h53;
localparam logic [7:0] ADDR_FAN_A_PERIOD_LIMIT_LO = 8'h54;
localparam logic [7:0] ADDR_FAN_A_PERIOD_LIMIT_HI = 8'h55;
localparam logic [7:0] ADDR_FAN_B_PERIOD_LIMIT_LO = 8'h56;
localparam logic [7:0] ADDR_FAN_B_PERIOD_LIMIT_HI = 8'h57;
localparam logic [7:0] ADDR_FAN_C_PERIOD_LIMIT_LO = 8'h58;
localparam logic [7:0] ADDR_FAN_C_PERIOD_LIMIT_HI = 8'h59;
localparam logic [7:0] ADDR_FAN_D_PERIOD_LIMIT_LO = 8'h5a;
localparam logic [7:0] ADDR_FAN_D_PERIOD_LIMIT_HI = 8'h5b;
localparam logic [7:0] ADDR_REMOTE_A_OVERTEMP_LIMIT = 8'h6a;
localparam logic [7:0] ADDR_LOCAL_OVERTEMP_LIMIT    = 8'h6b;
localparam logic [7:0] ADDR_REMOTE_B_OVERTEMP_LIMIT = 8'h6c;
localparam logic [7:0] ADDR_OVERTEMP_PIN_TIME_LIMIT = 8'h7a;

localparam int CH_N  = 5;
localparam int LIM_N = 22;
localparam logic [2:0] CH_SUPPLY_A = 3'h0;
localparam logic [2:0] CH_REMOTE_A = 3'h2;
localparam logic [2:0] CH_LOCAL    = 3'h3;
localparam logic [2:0] CH_LAST     = 3'h4;

// limit table order: supply a, supply b, remote a, local, remote b,
// fan a..d low/high, overtemp remote a, local, remote b, pin time
localparam logic [LIM_N-1:0][7:0] LIM_ADDR = {
    ADDR_OVERTEMP_PIN_TIME_LIMIT, ADDR_REMOTE_B_OVERTEMP_LIMIT,
    ADDR_LOCAL_OVERTEMP_LIMIT, ADDR_REMOTE_A_OVERTEMP_LIMIT,
    ADDR_FAN_D_PERIOD_LIMIT_HI, ADDR_FAN_D_PERIOD_LIMIT_LO,
    ADDR_FAN_C_PERIOD_LIMIT_HI, ADDR_FAN_C_PERIOD_LIMIT_LO,
    ADDR_FAN_B_PERIOD_LIMIT_HI, ADDR_FAN_B_PERIOD_LIMIT_LO,
    ADDR_FAN_A_PERIOD_LIMIT_HI, ADDR_FAN_A_PERIOD_LIMIT_LO,
    ADDR_REMOTE_B_TEMP_HIGH_LIMIT, ADDR_REMOTE_B_TEMP_LOW_LIMIT,
    ADDR_LOCAL_TEMP_HIGH_LIMIT, ADDR_LOCAL_TEMP_LOW_LIMIT,
    ADDR_REMOTE_A_TEMP_HIGH_LIMIT, ADDR_REMOTE_A_TEMP_LOW_LIMIT,
    ADDR_SUPPLY_B_HIGH_LIMIT, ADDR_SUPPLY_B_LOW_LIMIT,
    ADDR_SUPPLY_A_HIGH_LIMIT, ADDR_SUPPLY_A_LOW_LIMIT};
localparam logic [LIM_N-1:0][7:0] LIM_RST = {
    8'h00, 8'h64, 8'h64, 8'h64, {8{8'hff}},
    8'h7f, 8'h81, 8'h7f, 8'h81, 8'h7f, 8'h81,
    8'hff, 8'h00, 8'hff, 8'h00};
localparam logic [CH_N-1:0][7:0] VAL_ADDR = {
    ADDR_REMOTE_B_VALUE, ADDR_LOCAL_VALUE, ADDR_REMOTE_A_VALUE,
    ADDR_SUPPLY_B_VALUE, ADDR_SUPPLY_A_VALUE};
localparam int LIM_FAN_BASE = 10;
localparam int LIM_OVT_BASE = 18;
localparam int LIM_TIMER    = 21;
localparam logic [4:0] LIM_NONE = 5'h1f;

// status vector: [7:0] primary, [15:8] secondary
localparam logic [CH_N-1:0][3:0] CH_BIT = {4'h6, 4'h5, 4'h4, 4'h2, 4'h0};
localparam int B_LOCAL   = 5;
localparam int B_SUMMARY = 7;
localparam int B_OVT     = 9;
localparam int B_FAN_A   = 10;
localparam int B_FAN_D   = 13;
localparam int B_DIODE_A = 14;
localparam int B_DIODE_B = 15;
localparam logic [15:0] PRI_USED = 16'h0075;
localparam logic [15:0] SEC_USED = 16'hfe00;

localparam int CLK_MHZ         = 40;
localparam int SLOT_SUPPLY_US  = 11380;
localparam int SLOT_LOCAL_US   = 12000;
localparam int SLOT_REMOTE_US  = 25500;
localparam int RR_GAP_US       = 35000;
localparam int SLOT_SUPPLY_CYC = SLOT_SUPPLY_US * CLK_MHZ;
localparam int SLOT_LOCAL_CYC  = SLOT_LOCAL_US * CLK_MHZ;
localparam int SLOT_REMOTE_CYC = SLOT_REMOTE_US * CLK_MHZ;
localparam int RR_GAP_CYC      = RR_GAP_US * CLK_MHZ;
localparam int CNT_W           = 21;

typedef enum logic [1:0] {M_IDLE, M_CONV, M_GAP} mode_t;

typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
} reg_req_t;

typedef struct packed {
    logic        valid;
    logic [1:0]  sel;
    logic [15:0] period;
} fan_sample_t;

typedef struct packed {
    mode_t                      mode;
    logic [2:0]                 ch;
    logic [CNT_W-1:0]           cnt;
    logic                       conv_start;
    logic                       start;
    logic                       alert_a_en;
    logic                       alert_b_en;
    logic                       pin_mode;
    logic [CH_N-1:0]            hot;
    logic [15:0]                cond;
    logic [15:0]                sticky;
    logic [15:0]                mask;
    logic [CH_N-1:0][7:0]       value;
    logic [LIM_N-1:0][7:0]      lim;
    logic [7:0]                 rdata;
    logic                       alert_a;
    logic                       alert_b;
} state_t;

function automatic logic [4:0] lim_idx(input logic [7:0] a);
    lim_idx = LIM_NONE;
    for (int i = 0; i < LIM_N; i++)
        if (LIM_ADDR[i] == a) lim_idx = 5'(i);
endfunction

function automatic state_t rst_state();
    state_t r;
    r = '0;
    r.mode = M_IDLE;
    r.lim = LIM_RST;
    return r;
endfunction

endpackage

// >>> rtl/limit_compare_status_alert.sv
`timescale 1ns/10ps
module limit_compare_status_alert
    import hwmon_pkg::*;
#(
    parameter int SUPPLY_CYC = SLOT_SUPPLY_CYC,
    parameter int LOCAL_CYC  = SLOT_LOCAL_CYC,
    parameter int REMOTE_CYC = SLOT_REMOTE_CYC,
    parameter int GAP_CYC    = RR_GAP_CYC
) (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire reg_req_t    REG_REQ,
    output wire logic [7:0]  REG_RDATA,
    input  wire logic [7:0]  ADC_VALUE,
    output wire logic [2:0]  CONV_CH,
    output wire logic        CONV_START,
    input  wire fan_sample_t FAN_IN,
    input  wire logic [1:0]  DIODE_FAULT,
    input  wire logic [7:0]  PIN_TIME,
    output wire logic        ALERT_A_O,
    output wire logic        ALERT_A_OE_N,
    output wire logic        ALERT_B_O,
    output wire logic        ALERT_B_OE_N
);

////////////////////////////////////////////////////////////////////////

localparam state_t S_RST = rst_state();

state_t      s_r;
state_t      s_nxt;
logic        slot_done;
logic        rd_pri;
logic        rd_sec;
logic [7:0]  lo;
logic [7:0]  hi;
logic [7:0]  ovl;
logic        is_temp;
logic        over;
logic        under;
logic        hot;
logic [15:0] fan_lim;
logic        fan_slow;
logic [4:0]  li;
logic        pend;

////////////////////////////////////////////////////////////////////////

function automatic logic [CNT_W-1:0] slot_len(input logic [2:0] c);
    if (c < CH_REMOTE_A)
        slot_len = CNT_W'(SUPPLY_CYC - 1);
    else if (c == CH_LOCAL)
        slot_len = CNT_W'(LOCAL_CYC - 1);
    else
        slot_len = CNT_W'(REMOTE_CYC - 1);
endfunction

// limits of the channel whose slot is ending
assign lo  = s_r.lim[2 * s_r.ch];
assign hi  = s_r.lim[2 * s_r.ch + 1];
assign ovl = s_r.lim[LIM_OVT_BASE + int'(s_r.ch) - int'(CH_REMOTE_A)];
assign is_temp = (s_r.ch >= CH_REMOTE_A);

// temperatures are two's complement, supplies are unsigned
always_comb begin
    if (is_temp) begin
        over  = $signed(ADC_VALUE) > $signed(hi);
        under = $signed(ADC_VALUE) <= $signed(lo);
        hot   = $signed(ADC_VALUE) > $signed(ovl);
    end else begin
        over  = ADC_VALUE > hi;
        under = ADC_VALUE <= lo;
        hot   = 1'b0;
    end
end

// fan checks need no sequencer state at all
assign fan_lim  = {s_r.lim[LIM_FAN_BASE + 2 * FAN_IN.sel + 1],
                   s_r.lim[LIM_FAN_BASE + 2 * FAN_IN.sel]};
assign fan_slow = FAN_IN.period > fan_lim;

assign li     = lim_idx(REG_REQ.addr);
assign rd_pri = REG_REQ.rd && (REG_REQ.addr == ADDR_STATUS_PRIMARY);
assign rd_sec = REG_REQ.rd && (REG_REQ.addr == ADDR_STATUS_SECONDARY);

////////////////////////////////////////////////////////////////////////

always_comb begin
    logic [15:0] clr;
    logic [7:0]  rd;
    s_nxt = s_r;
    s_nxt.conv_start = 1'b0;
    slot_done = 1'b0;
    clr = '0;
    rd = '0;

    // round-robin sequencer
    case (s_r.mode)
        M_IDLE: begin
            if (s_r.start) begin
                s_nxt.mode = M_CONV;
                s_nxt.ch = CH_SUPPLY_A;
                s_nxt.cnt = slot_len(CH_SUPPLY_A);
                s_nxt.conv_start = 1'b1;
            end
        end
        M_CONV: begin
            if (!s_r.start) begin
                s_nxt.mode = M_IDLE;
            end else if (s_r.cnt != '0) begin
                s_nxt.cnt = s_r.cnt - 1'b1;
            end else begin
                slot_done = 1'b1;
                s_nxt.value[s_r.ch] = ADC_VALUE;
                s_nxt.cond[CH_BIT[s_r.ch]] = over || under;
                if (is_temp)
                    s_nxt.hot[s_r.ch] = hot;
                if (s_r.ch == CH_LAST) begin
                    s_nxt.mode = M_GAP;
                    s_nxt.cnt = CNT_W'(GAP_CYC - 1);
                end else begin
                    s_nxt.ch = s_r.ch + 3'h1;
                    s_nxt.cnt = slot_len(s_r.ch + 3'h1);
                    s_nxt.conv_start = 1'b1;
                end
            end
        end
        M_GAP: begin
            if (!s_r.start) begin
                s_nxt.mode = M_IDLE;
            end else if (s_r.cnt != '0) begin
                s_nxt.cnt = s_r.cnt - 1'b1;
            end else begin
                s_nxt.mode = M_CONV;
                s_nxt.ch = CH_SUPPLY_A;
                s_nxt.cnt = slot_len(CH_SUPPLY_A);
                s_nxt.conv_start = 1'b1;
            end
        end
        default: s_nxt.mode = M_IDLE;
    endcase

    s_nxt.cond[B_OVT] = |s_nxt.hot;

    // fan samples land whenever they arrive; fan d ones only outside pin mode
    if (FAN_IN.valid) begin
        if (!(FAN_IN.sel == 2'h3 && s_r.pin_mode))
            s_nxt.cond[B_FAN_A + int'(FAN_IN.sel)] = fan_slow;
    end
    if (s_r.pin_mode)
        s_nxt.cond[B_FAN_D] = PIN_TIME > s_r.lim[LIM_TIMER];
    s_nxt.cond[B_DIODE_A] = DIODE_FAULT[0];
    s_nxt.cond[B_DIODE_B] = DIODE_FAULT[1];

    // register writes
    if (REG_REQ.wr) begin
        case (REG_REQ.addr)
            ADDR_CONFIG_1: s_nxt.start = REG_REQ.wdata[0];
            ADDR_MASK_1:   s_nxt.mask[7:0] = REG_REQ.wdata;
            ADDR_MASK_2:   s_nxt.mask[15:8] = REG_REQ.wdata;
            ADDR_CONFIG_3: begin
                s_nxt.alert_a_en = REG_REQ.wdata[0];
                s_nxt.pin_mode = REG_REQ.wdata[1];
            end
            ADDR_CONFIG_4: s_nxt.alert_b_en = REG_REQ.wdata[0];
            default: begin
                if (li != LIM_NONE)
                    s_nxt.lim[li] = REG_REQ.wdata;
            end
        endcase
    end

    // a read clears only bits whose cause is gone; set wins
    if (rd_pri)
        clr = clr | PRI_USED;
    if (rd_sec)
        clr = clr | SEC_USED;
    s_nxt.sticky = (s_r.sticky & ~clr) | s_nxt.cond;

    // masks gate only the alert, status above is untouched
    s_nxt.alert_a = s_nxt.alert_a_en && alert_pend(s_nxt);
    s_nxt.alert_b = s_nxt.alert_b_en && alert_pend(s_nxt);

    // read data, captured on the read strobe
    case (REG_REQ.addr)
        ADDR_CONFIG_1: rd = {7'h00, s_r.start};
        ADDR_STATUS_PRIMARY:
            rd = {|s_r.sticky[15:8], s_r.sticky[6:0]};
        ADDR_STATUS_SECONDARY: rd = s_r.sticky[15:8];
        ADDR_MASK_1:   rd = s_r.mask[7:0];
        ADDR_MASK_2:   rd = s_r.mask[15:8];
        ADDR_CONFIG_3: rd = {6'h00, s_r.pin_mode, s_r.alert_a_en};
        ADDR_CONFIG_4: rd = {7'h00, s_r.alert_b_en};
        default: begin
            if (li != LIM_NONE)
                rd = s_r.lim[li];
            for (int i = 0; i < CH_N; i++)
                if (VAL_ADDR[i] == REG_REQ.addr)
                    rd = s_r.value[i];
        end
    endcase
    if (REG_REQ.rd)
        s_nxt.rdata = rd;
end

// summary mask bit 7 also silences every secondary source
function automatic logic alert_pend(input state_t s);
    logic p;
    logic q;
    p = |(s.sticky[7:0] & ~s.mask[7:0] & PRI_USED[7:0]);
    q = |(s.sticky[15:8] & ~s.mask[15:8]) & ~s.mask[B_SUMMARY];
    alert_pend = p || q;
endfunction

always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N)
        s_r <= S_RST;
    else
        s_r <= s_nxt;
end

////////////////////////////////////////////////////////////////////////

// open drain: the pins only ever pull low
assign ALERT_A_O    = 1'b0;
assign ALERT_B_O    = 1'b0;
assign ALERT_A_OE_N = !s_r.alert_a;
assign ALERT_B_OE_N = !s_r.alert_b;
assign REG_RDATA    = s_r.rdata;
assign CONV_CH      = s_r.ch;
assign CONV_START   = s_r.conv_start;

assign pend = alert_pend(s_r);

////////////////////////////////////////////////////////////////////////

default clocking cb @(posedge CLK);
endclocking
default disable iff (!RESET_N);

property p_high_eq;
    slot_done && s_r.ch == CH_SUPPLY_A && ADC_VALUE == hi && ADC_VALUE > lo
        |=> !s_r.cond[0];
endproperty
a_high_eq: assert property (p_high_eq) else $error("equal high flagged");

property p_low_eq;
    slot_done && s_r.ch == CH_SUPPLY_A && ADC_VALUE == lo
        |=> s_r.cond[0] && s_r.sticky[0];
endproperty
a_low_eq: assert property (p_low_eq) else $error("equal low missed");

property p_stop;
    !s_r.start |=> s_r.mode == M_IDLE && !CONV_START;
endproperty
a_stop: assert property (p_stop) else $error("ran while stopped");

property p_store;
    slot_done |=> s_r.value[$past(s_r.ch)] == $past(ADC_VALUE);
endproperty
a_store: assert property (p_store) else $error("value not stored");

property p_slot;
    CONV_START |-> s_r.mode == M_CONV && s_r.cnt == slot_len(s_r.ch);
endproperty
a_slot: assert property (p_slot) else $error("slot length wrong");

property p_gap;
    slot_done && s_r.ch == CH_LAST
        |=> s_r.mode == M_GAP && s_r.cnt == CNT_W'(GAP_CYC - 1);
endproperty
a_gap: assert property (p_gap) else $error("gap not entered");

property p_fan;
    FAN_IN.valid && FAN_IN.sel == 2'h0 && fan_slow
        |=> s_r.sticky[B_FAN_A] [*2];
endproperty
a_fan: assert property (p_fan) else $error("slow fan missed");

property p_sticky;
    s_r.sticky[B_LOCAL] && !rd_pri |=> s_r.sticky[B_LOCAL];
endproperty
a_sticky: assert property (p_sticky) else $error("sticky lost");

property p_summary;
    rd_pri |=> REG_RDATA[B_SUMMARY] == $past(|s_r.sticky[15:8]);
endproperty
a_summary: assert property (p_summary) else $error("summary wrong");

property p_status_set;
    s_r.cond[B_LOCAL] && s_r.mask[B_LOCAL] |-> s_r.sticky[B_LOCAL];
endproperty
a_status_set: assert property (p_status_set) else $error("masked lost");

property p_alert;
    ALERT_A_OE_N == !(s_r.alert_a_en && pend);
endproperty
a_alert: assert property (p_alert) else $error("alert mismatch");

c_gap:   cover property (slot_done && s_r.ch == CH_LAST);
c_alert: cover property (s_r.alert_a_en ##1 !ALERT_A_OE_N);
c_clear: cover property (rd_pri && s_r.sticky[B_LOCAL]
                         ##1 !s_r.sticky[B_LOCAL]);

endmodule

// >>> verif/host_model.sv
`timescale 1ns/10ps
module host_model
    import hwmon_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output reg_req_t        req
);
////////////////////////////////////////////////////////////////////////
initial req = '0;

// strobe held one cycle, lowered on the edge that takes it
task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, dat};
    @(posedge clk);
    req <= '0;
endtask

// data is sampled after the taking edge has settled
task automatic rd(input logic [7:0] a, output logic [7:0] dat);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    #1 dat = rdata;
endtask

// secondary only read when the summary says it holds something
task automatic poll(output logic [7:0] p, output logic [7:0] s);
    rd(ADDR_STATUS_PRIMARY, p);
    s = 8'h00;
    if (p[7] === 1'b1) rd(ADDR_STATUS_SECONDARY, s);
endtask
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import hwmon_pkg::*;
;
localparam int SUP = 4;
localparam int LOC = 5;
localparam int REM = 6;
localparam int GAP = 8;

logic        clk;
logic        reset_n;
reg_req_t    reg_req;
logic [7:0]  reg_rdata;
logic [7:0]  adc_value;
logic [2:0]  conv_ch;
logic        conv_start;
fan_sample_t fan_in;
logic [1:0]  diode_fault;
logic [7:0]  pin_time;
logic        alert_a_o;
logic        alert_a_oe_n;
logic        alert_b_o;
logic        alert_b_oe_n;
logic [7:0]  tab [5];
logic [7:0]  d;
logic [7:0]  p;
logic [7:0]  s;
int          miscompares;
int          checks;
int          cycles;
int          n;

////////////////////////////////////////////////////////////////////////
limit_compare_status_alert #(
    .SUPPLY_CYC (SUP),
    .LOCAL_CYC  (LOC),
    .REMOTE_CYC (REM),
    .GAP_CYC    (GAP)
) u_dut (
    .CLK          (clk),
    .RESET_N      (reset_n),
    .REG_REQ      (reg_req),
    .REG_RDATA    (reg_rdata),
    .ADC_VALUE    (adc_value),
    .CONV_CH      (conv_ch),
    .CONV_START   (conv_start),
    .FAN_IN       (fan_in),
    .DIODE_FAULT  (diode_fault),
    .PIN_TIME     (pin_time),
    .ALERT_A_O    (alert_a_o),
    .ALERT_A_OE_N (alert_a_oe_n),
    .ALERT_B_O    (alert_b_o),
    .ALERT_B_OE_N (alert_b_oe_n)
);

host_model u_host (
    .clk   (clk),
    .rdata (reg_rdata),
    .req   (reg_req)
);

////////////////////////////////////////////////////////////////////////
initial clk = 1'b0;
always #12.5 clk = ~clk;

// analog source: value of the channel now being converted
always @(posedge clk) adc_value <= tab[conv_ch];

// whole run needs well under a thousand cycles
always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
        miscompares++;
        finish_test();
    end
end

////////////////////////////////////////////////////////////////////////
task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
        miscompares++;
        $display("BAD %0t got %h exp %h", $time, got, exp);
    end
endtask

task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
        miscompares++;
        $display("BAD %0t got %h exp %h", $time, got, exp);
    end
endtask

task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, d);
    chk8(d, e);
endtask

task automatic wait_ch0();
    int k;
    k = 0;
    do begin
        @(posedge clk);
        k++;
    end while (!(conv_start === 1'b1 && conv_ch === 3'h0) && k < 200);
    if (k >= 200) miscompares++;
endtask

// a full pass with the current table: first start, then the next one
task automatic wait_round();
    wait_ch0();
    wait_ch0();
endtask

task automatic fan_pulse(input int f, input logic [15:0] per);
    @(posedge clk);
    fan_in <= '{1'b1, 2'(f), per};
    @(posedge clk);
    fan_in <= '0;
endtask

task automatic finish_test();
    if (miscompares == 0 && checks > 0) begin
        $display("No errors found");
    end else begin
        $display("Errors were found");
    end
    $finish;
endtask

////////////////////////////////////////////////////////////////////////
initial begin
    int exp_len [5];
    exp_len = '{SUP, SUP, REM, LOC, REM + GAP};
    tab = '{8'hc0, 8'h10, 8'h00, 8'h20, 8'h64};
    reset_n = 1'b0;
    adc_value = 8'h00;
    fan_in = '0;
    diode_fault = 2'b00;
    pin_time = 8'h00;
    miscompares = 0;
    checks = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    // register table: defaults, read/write, refusals
    for (int i = 0; i < LIM_N; i++) begin
        rdc(LIM_ADDR[i], LIM_RST[i]);
        u_host.wr(LIM_ADDR[i], LIM_RST[i] ^ 8'h5a);
        rdc(LIM_ADDR[i], LIM_RST[i] ^ 8'h5a);
        u_host.wr(LIM_ADDR[i], LIM_RST[i]);
    end
    rdc(ADDR_MASK_1, 8'h00);
    rdc(8'h10, 8'h00);
    u_host.wr(ADDR_STATUS_PRIMARY, 8'hff);
    rdc(ADDR_STATUS_PRIMARY, 8'h00);
    chk1(alert_a_oe_n, 1'b1);
    chk1(alert_a_o, 1'b0);
    // sequencing, slot lengths, boundaries that must not flag
    u_host.wr(ADDR_SUPPLY_A_HIGH_LIMIT, 8'hc0);
    u_host.wr(ADDR_CONFIG_1, 8'h01);
    wait_ch0();
    for (int c = 0; c < 5; c++) begin
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (conv_start !== 1'b1 && n < 100);
        chk8(8'(n), 8'(exp_len[c]));
        chk8({5'h00, conv_ch}, 8'((c + 1) % 5));
    end
    rdc(ADDR_STATUS_PRIMARY, 8'h00);
    rdc(ADDR_STATUS_SECONDARY, 8'h00);
    rdc(ADDR_SUPPLY_A_VALUE, 8'hc0);
    rdc(ADDR_REMOTE_B_VALUE, 8'h64);
    // every analog channel out of limits, temps compared signed
    // remote b high limit lowered so the same reading trips both checks
    u_host.wr(ADDR_REMOTE_B_TEMP_HIGH_LIMIT, 8'h64);
    tab = '{8'hc1, 8'h00, 8'h80, 8'h81, 8'h65};
    wait_round();
    rdc(ADDR_STATUS_PRIMARY, 8'hf5);
    rdc(ADDR_STATUS_PRIMARY, 8'hf5);
    u_host.poll(p, s);
    chk8(p, 8'hf5);
    chk8(s, 8'h02);
    tab = '{8'hc0, 8'h10, 8'h00, 8'h20, 8'h64};
    wait_round();
    rdc(ADDR_STATUS_PRIMARY, 8'hf5);
    rdc(ADDR_STATUS_PRIMARY, 8'h80);
    rdc(ADDR_STATUS_SECONDARY, 8'h02);
    rdc(ADDR_STATUS_PRIMARY, 8'h00);
    rdc(ADDR_STATUS_SECONDARY, 8'h00);
    // stop: no further slots, value registers frozen
    u_host.wr(ADDR_CONFIG_1, 8'h00);
    tab[0] = 8'h33;
    repeat (2) @(posedge clk);
    n = 0;
    repeat (60) begin
        @(posedge clk);
        if (conv_start === 1'b1) n++;
    end
    chk8(8'(n), 8'h00);
    rdc(ADDR_SUPPLY_A_VALUE, 8'hc0);
    // fans with the analog side stopped; equal period is not slow
    for (int f = 0; f < 4; f++) begin
        u_host.wr(LIM_ADDR[LIM_FAN_BASE + 2 * f], 8'h34);
        u_host.wr(LIM_ADDR[LIM_FAN_BASE + 2 * f + 1], 8'h12);
        fan_pulse(f, 16'h1234);
    end
    rdc(ADDR_STATUS_SECONDARY, 8'h00);
    u_host.wr(ADDR_MASK_1, 8'h80);
    u_host.wr(ADDR_CONFIG_3, 8'h01);
    for (int f = 0; f < 4; f++) fan_pulse(f, 16'h1235);
    @(posedge clk);
    diode_fault <= 2'b11;
    repeat (3) @(posedge clk);
    chk1(alert_a_oe_n, 1'b1);
    u_host.poll(p, s);
    chk8(p, 8'h80);
    chk8(s, 8'hfc);
    u_host.wr(ADDR_MASK_1, 8'h00);
    repeat (3) @(posedge clk);
    chk1(alert_a_oe_n, 1'b0);
    chk1(alert_b_oe_n, 1'b1);
    u_host.wr(ADDR_CONFIG_4, 8'h01);
    repeat (3) @(posedge clk);
    chk1(alert_b_oe_n, 1'b0);
    for (int f = 0; f < 4; f++) fan_pulse(f, 16'h1000);
    @(posedge clk);
    diode_fault <= 2'b00;
    repeat (3) @(posedge clk);
    chk1(alert_a_oe_n, 1'b0);
    rdc(ADDR_STATUS_SECONDARY, 8'hfc);
    repeat (3) @(posedge clk);
    chk1(alert_a_oe_n, 1'b1);
    rdc(ADDR_STATUS_SECONDARY, 8'h00);
    // pin-time mode: fan d samples ignored, bit 5 from the timer
    u_host.wr(ADDR_CONFIG_3, 8'h03);
    fan_pulse(3, 16'hffff);
    rdc(ADDR_STATUS_SECONDARY, 8'h00);
    @(posedge clk);
    pin_time <= 8'h01;
    repeat (2) @(posedge clk);
    rdc(ADDR_STATUS_SECONDARY, 8'h20);
    chk1(alert_a_oe_n, 1'b0);
    u_host.wr(ADDR_OVERTEMP_PIN_TIME_LIMIT, 8'h01);
    rdc(ADDR_STATUS_SECONDARY, 8'h20);
    rdc(ADDR_STATUS_SECONDARY, 8'h00);
    finish_test();
end
endmodule
